// file: logic/nand_bus_cycle_decode.sv
// Purpose: host controller driving a nand flash device over its strobe bus
// Assumes: device pins sampled synchronously to ref_clk
// Notes:   one strobe phase per clock; 80 ns read cycle is above the edo limit
`timescale 1ns/1ps
module nand_bus_cycle_decode
    import nand_host_pkg::*;
#(
    parameter int unsigned INIT_CYC  = nand_host_pkg::INIT_WAIT_CYC,
    parameter int unsigned RESET_CYC = nand_host_pkg::FIRST_RST_CYC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire nand_host_pkg::op_t   op,
    input  wire logic                 op_valid,
    output logic                      op_ready,
    input  wire logic                 op_target,
    input  wire logic [7:0]           op_byte,
    input  wire logic [nand_host_pkg::COL_BITS-1:0] op_col,
    input  wire logic [nand_host_pkg::ROW_BITS-1:0] op_row,
    input  wire logic                 guard_release,
    output logic [7:0]                rd_data,
    output logic                      rd_valid,
    output logic                      init_done,
    output logic                      target_busy,
    output nand_host_pkg::nand_ctl_t  ctl,
    output logic [7:0]                io_out,
    output logic                      io_oe,
    input  wire logic [7:0]           io_in,
    input  wire logic                 ready_busy_n,
    input  wire logic                 second_ready_busy_n
);
    import nand_host_pkg::*;

    // -----------------------------------------------------------------
    // states and address helper
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_POWER  = 4'b0000,
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_LOW    = 4'b0011,
        ST_HIGH   = 4'b0100,
        ST_RDLOW  = 4'b0101,
        ST_RDHIGH = 4'b0110,
        ST_BUSYW  = 4'b0111
    } state_t;

    // address byte for cycle k, high bits masked low
    function automatic logic [7:0] addr_byte(input logic [2:0] k,
                                             input logic [COL_BITS-1:0] c,
                                             input logic [ROW_BITS-1:0] r);
        case (k)
            3'h0:    addr_byte = c[7:0];
            3'h1:    addr_byte = {4'h0, c[11:8]} & COL_HI_MASK;
            3'h2:    addr_byte = r[7:0];
            3'h3:    addr_byte = r[15:8];
            default: addr_byte = r[23:16] & ROW_HI_MASK;
        endcase
    endfunction

    state_t          state_reg;
    op_t             cur_op_reg;
    logic            tgt_reg;
    logic [2:0]      idx_reg;
    logic [23:0]     wait_reg;
    logic [1:0]      init_step_reg;
    logic            rb_low_seen_reg;
    logic [COL_BITS-1:0] col_reg;
    logic [ROW_BITS-1:0] row_reg;
    logic            rb_sel;

    // -----------------------------------------------------------------
    // busy mapping and request gate
    // -----------------------------------------------------------------
    assign rb_sel      = tgt_reg ? second_ready_busy_n : ready_busy_n;
    assign target_busy = ~(op_target ? second_ready_busy_n : ready_busy_n);
    // status and reset may go out while busy
    // no bad-block table here: the user keeps invalid blocks out of op_row
    assign op_ready    = (state_reg == ST_IDLE) &&
                         (~target_busy || (op == OP_CMD &&
                          (op_byte == CMD_STATUS || op_byte == CMD_STATUS_MULTI ||
                           op_byte == CMD_RESET)));

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg       <= ST_POWER;
            cur_op_reg      <= OP_NONE;
            tgt_reg         <= 1'b0;
            idx_reg         <= 3'h0;
            wait_reg        <= 24'h000000;
            init_step_reg   <= 2'h0;
            rb_low_seen_reg <= 1'b0;
            col_reg         <= '0;
            row_reg         <= '0;
            init_done       <= 1'b0;
            ctl             <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            io_out          <= 8'h00;
            io_oe           <= 1'b0;
            rd_data         <= 8'h00;
            rd_valid        <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            case (state_reg)
                ST_POWER: begin
                    // hold off after power, then reset per select
                    // selects are released here, in the hold-off and after each power-up reset's busy wait
                    ctl.chip_select_n        <= 1'b1;
                    ctl.second_chip_select_n <= 1'b1;
                    if (wait_reg < INIT_CYC[23:0]) begin
                        wait_reg <= wait_reg + 24'h000001;
                    end else if (init_step_reg == 2'h2) begin
                        init_done <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else begin
                        tgt_reg    <= init_step_reg[0];
                        cur_op_reg <= OP_CMD;
                        io_out     <= CMD_RESET;
                        init_step_reg <= init_step_reg + 2'h1;
                        state_reg  <= ST_SETUP;
                    end
                end
                ST_IDLE: begin
                    ctl.chip_select_n        <= 1'b1;
                    ctl.second_chip_select_n <= 1'b1;
                    ctl.write_guard_n        <= guard_release;
                    io_oe <= 1'b0;
                    if (op_valid && op_ready && op != OP_NONE) begin
                        cur_op_reg <= op;
                        tgt_reg    <= op_target;
                        col_reg    <= op_col;
                        row_reg    <= op_row;
                        idx_reg    <= 3'h0;
                        io_out     <= (op == OP_ADDR5) ? addr_byte(3'h0, op_col, op_row)
                                                       : op_byte;
                        state_reg  <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    ctl.chip_select_n        <= tgt_reg;
                    ctl.second_chip_select_n <= ~tgt_reg;
                    ctl.command_latch_strobe <= (cur_op_reg == OP_CMD);
                    ctl.address_latch_strobe <= (cur_op_reg == OP_ADDR5);
                    io_oe     <= (cur_op_reg != OP_READ);
                    state_reg <= (cur_op_reg == OP_READ) ? ST_RDLOW : ST_LOW;
                end
                ST_LOW: begin
                    // next address byte goes out with the falling strobe, so the
                    // previous byte still stands through the rising edge
                    ctl.write_strobe_n <= 1'b0;
                    if (cur_op_reg == OP_ADDR5) begin
                        io_out <= addr_byte(idx_reg, col_reg, row_reg);
                    end
                    state_reg <= ST_HIGH;
                end
                ST_HIGH: begin
                    // rising write strobe latches the byte
                    ctl.write_strobe_n <= 1'b1;
                    if (cur_op_reg == OP_ADDR5 && idx_reg != 3'(ADDR_CYCLES - 1)) begin
                        idx_reg   <= idx_reg + 3'h1;
                        state_reg <= ST_LOW;
                    end else if (cur_op_reg == OP_CMD && (io_out != CMD_STATUS &&
                                 io_out != CMD_STATUS_MULTI)) begin
                        rb_low_seen_reg <= 1'b0;
                        wait_reg        <= 24'h000000;
                        state_reg       <= ST_BUSYW;
                    end else begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RDLOW: begin
                    // one 40 ns phase each side, normal sampling
                    ctl.read_strobe_n <= 1'b0;
                    state_reg <= ST_RDHIGH;
                end
                ST_RDHIGH: begin
                    rd_data  <= io_in;
                    rd_valid <= 1'b1;
                    ctl.read_strobe_n <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                ST_BUSYW: begin
                    // wait through low pulse, bounded for short busy
                    // a command with no busy answer still waits RESET_CYC, covering the gap
                    wait_reg <= wait_reg + 24'h000001;
                    if (!rb_sel) begin
                        rb_low_seen_reg <= 1'b1;
                    end
                    if ((rb_low_seen_reg && rb_sel) || wait_reg >= RESET_CYC[23:0]) begin
                        state_reg <= init_done ? ST_IDLE : ST_POWER;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (state_reg == ST_POWER || state_reg == ST_IDLE) begin
                ctl.command_latch_strobe <= 1'b0;
                ctl.address_latch_strobe <= 1'b0;
            end
        end
    end
endmodule

// file: logic/nand_host_pkg.sv
// Purpose: shared constants and types for the nand bus host controller
// Assumes: 25 MHz ref_clk
// Notes:   bus pin group travels as a packed struct
package nand_host_pkg;
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned CLK_NS          = 40;
    // -----------------------------------------------------------------
    // timing, in their own units
    // -----------------------------------------------------------------
    localparam int unsigned INIT_WAIT_MS    = 10;
    localparam int unsigned FIRST_RST_MS    = 1;
    localparam int unsigned READ_CYCLE_NS   = 80;
    localparam int unsigned EDO_LIMIT_NS    = 30;
    localparam int unsigned INIT_WAIT_CYC   = INIT_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned FIRST_RST_CYC   = FIRST_RST_MS * (CLK_HZ / 1000);
    localparam int unsigned STROBE_CYC      = 1;
    // -----------------------------------------------------------------
    // command codes and field layout
    // -----------------------------------------------------------------
    localparam logic [7:0] CMD_RESET        = 8'hff;
    localparam logic [7:0] CMD_STATUS       = 8'h70;
    localparam logic [7:0] CMD_STATUS_MULTI = 8'h78;
    localparam int unsigned ADDR_CYCLES     = 5;
    localparam int unsigned COL_BITS        = 12;
    localparam int unsigned ROW_BITS        = 24;
    localparam logic [7:0] COL_HI_MASK      = 8'h0f;
    localparam logic [7:0] ROW_HI_MASK      = 8'h07;

    typedef enum logic [2:0] {
        OP_NONE   = 3'b000,
        OP_CMD    = 3'b001,
        OP_ADDR5  = 3'b010,
        OP_WRITE  = 3'b011,
        OP_READ   = 3'b100
    } op_t;

    typedef struct packed {
        logic       chip_select_n;
        logic       second_chip_select_n;
        logic       command_latch_strobe;
        logic       address_latch_strobe;
        logic       write_strobe_n;
        logic       read_strobe_n;
        logic       write_guard_n;
    } nand_ctl_t;
endpackage

// file: tb/nand_bus_cycle_decode_sva.sv
// Purpose: port checker for the nand bus host
// Assumes: sees only the top module ports
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
module nand_bus_cycle_decode_sva
    import nand_host_pkg::*;
#(
    parameter int unsigned INIT_CYC = 20
) (
    input wire logic                     ref_clk,
    input wire logic                     rst,
    input wire nand_host_pkg::op_t       op,
    input wire logic                     op_valid,
    input wire logic                     op_ready,
    input wire logic                     op_target,
    input wire logic                     rd_valid,
    input wire logic                     init_done,
    input wire logic                     target_busy,
    input wire nand_host_pkg::nand_ctl_t ctl,
    input wire logic                     io_oe,
    input wire logic                     ready_busy_n,
    input wire logic                     second_ready_busy_n
);
    int unsigned since_rst;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // saturating, so a long run never wraps back under the limit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) since_rst <= 0;
        else if (since_rst < INIT_CYC) since_rst <= since_rst + 1;
    end
    chk_cmd_strobe: assert property ($rose(ctl.write_strobe_n) && ctl.command_latch_strobe
        |-> !ctl.address_latch_strobe && io_oe) else $error("command strobe bad");
    chk_addr_strobe: assert property ($rose(ctl.write_strobe_n) && ctl.address_latch_strobe
        |-> !ctl.command_latch_strobe && io_oe) else $error("address strobe bad");
    chk_data_strobe: assert property ($rose(ctl.write_strobe_n) && !ctl.chip_select_n
        |-> io_oe) else $error("data strobe without drive");
    chk_read_release: assert property (!ctl.read_strobe_n |-> !io_oe)
        else $error("host drives io during read");
    chk_read_answer: assert property (op_valid && op_ready && op == OP_READ
        |-> ##[3:4] rd_valid) else $error("read answer late");
    chk_busy_map: assert property ((op_target ? !second_ready_busy_n : !ready_busy_n)
        |-> target_busy) else $error("busy not mapped");
    chk_refuse_busy: assert property (target_busy && op == OP_WRITE |-> !op_ready)
        else $error("write taken while busy");
    chk_init_wait: assert property (!(ctl.chip_select_n && ctl.second_chip_select_n) |-> since_rst >= INIT_CYC)
        else $error("select before init wait");
    chk_guard_init: assert property (!init_done |-> !ctl.write_guard_n)
        else $error("write guard released during power-up");
endmodule
bind nand_bus_cycle_decode nand_bus_cycle_decode_sva #(.INIT_CYC(INIT_CYC)) u_sva (
    .ref_clk(ref_clk), .rst(rst), .op(op), .op_valid(op_valid), .op_ready(op_ready),
    .op_target(op_target), .rd_valid(rd_valid), .init_done(init_done),
    .target_busy(target_busy), .ctl(ctl),
    .io_oe(io_oe), .ready_busy_n(ready_busy_n), .second_ready_busy_n(second_ready_busy_n));

// file: tb/nand_dev_model.sv
// Purpose: behavioural nand device on the far side of the host
// Assumes: strobes sampled on ref_clk
// Notes:   read data is the column byte counting up
`timescale 1ns/1ps
module nand_dev_model
    import nand_host_pkg::*;
#(
    parameter int unsigned FETCH_CYC = 8
) (
    input  wire logic                     ref_clk,
    input  wire nand_host_pkg::nand_ctl_t ctl,
    input  wire logic [7:0]               io_out,
    output logic [7:0]                    io_in,
    output logic                          ready_busy_n,
    output logic                          second_ready_busy_n,
    output logic [7:0]                    last_din,
    output logic                          addr_bad
);
    logic       we_q = 1'b1;
    logic       re_q = 1'b1;
    logic       stat = 1'b0;
    int         busy [2] = '{0, 0};
    int         acyc = 0;
    logic [7:0] col0 = 8'h00;
    logic [7:0] dout = 8'h00;
    logic [7:0] cmd;
    logic [7:0] cur;
    // held low, so program and erase start; held high they would not
    localparam bit SUPPLY_LOW = 1'b0;
    logic       sel;
    int         s;
    assign sel = !ctl.chip_select_n || !ctl.second_chip_select_n;
    assign s = ctl.chip_select_n ? 1 : 0;
    assign cmd = io_out;
    assign ready_busy_n = (busy[0] == 0);
    assign second_ready_busy_n = (busy[1] == 0);
    // no pull-up on io, so an idle bus shows the inverse of the last byte
    // byte shows while the read strobe is low, so the host samples it before the rise
    assign cur = stat ? {ctl.write_guard_n, {2{busy[s] == 0}}, 5'h00} : col0;
    assign io_in = (sel && !ctl.read_strobe_n) ? cur : ~dout;
    initial last_din = 8'h00;
    initial addr_bad = 1'b0;
    always @(posedge ref_clk) begin
        we_q <= ctl.write_strobe_n;
        re_q <= ctl.read_strobe_n;
        for (int i = 0; i < 2; i++) if (busy[i] > 0) busy[i] <= busy[i] - 1;
        if (sel && ctl.write_strobe_n && !we_q) begin
            if (ctl.command_latch_strobe && !ctl.address_latch_strobe) begin
                if (cmd == CMD_STATUS || cmd == CMD_STATUS_MULTI) stat <= 1'b1;
                else if (cmd == CMD_RESET) busy[s] <= 12;
                else if (busy[s] == 0) begin
                    stat <= 1'b0;
                    acyc <= 0;
                    if (cmd == 8'h30 || (!SUPPLY_LOW && cmd inside {8'h10, 8'hd0}))
                        busy[s] <= FETCH_CYC;
                end
            end else if (ctl.address_latch_strobe) begin
                acyc <= acyc + 1;
                if (acyc == 0) col0 <= io_out;
                if ((acyc == 1 && io_out[7:4] != 0) || (acyc == 4 && io_out[7:3] != 0))
                    addr_bad <= 1'b1;
            end else if (busy[s] == 0) last_din <= io_out;
        end
        if (sel && !ctl.read_strobe_n && re_q) begin
            dout <= cur;
            if (!stat) col0 <= col0 + 8'h01;
        end
    end
endmodule

// file: tb/nand_bus_cycle_decode_tb.sv
// Purpose: self-checking bench for the nand bus host
// Assumes: shortened init and reset counts
// Notes:   one op per handshake, waits are bounded
`timescale 1ns/1ps
module nand_bus_cycle_decode_tb;
    import nand_host_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, op_valid = 1'b0, op_target = 1'b0, guard_release = 1'b0;
    op_t op = OP_NONE;
    logic [7:0] op_byte = 8'h00, rd_data, io_out, io_in, last_din;
    logic [11:0] op_col = 12'h3a5;
    logic [23:0] op_row = 24'h071234;
    logic op_ready, rd_valid, init_done, target_busy, io_oe, rb_n, rb2_n, addr_bad;
    nand_ctl_t ctl;
    int err_count = 0, samples_checked = 0;
    always #20 ref_clk = ~ref_clk;
    nand_bus_cycle_decode #(.INIT_CYC(20), .RESET_CYC(20)) u_nand_bus_cycle_decode (
        .ref_clk(ref_clk), .rst(rst), .op(op), .op_valid(op_valid), .op_ready(op_ready),
        .op_target(op_target), .op_byte(op_byte), .op_col(op_col), .op_row(op_row),
        .guard_release(guard_release), .rd_data(rd_data), .rd_valid(rd_valid),
        .init_done(init_done), .target_busy(target_busy), .ctl(ctl), .io_out(io_out),
        .io_oe(io_oe), .io_in(io_in), .ready_busy_n(rb_n), .second_ready_busy_n(rb2_n));
    nand_dev_model #(.FETCH_CYC(40)) u_nand_dev_model (.ref_clk(ref_clk), .ctl(ctl),
        .io_out(io_out),
        .io_in(io_in), .ready_busy_n(rb_n), .second_ready_busy_n(rb2_n),
        .last_din(last_din), .addr_bad(addr_bad));
    task automatic close_out;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic send(input op_t o, input logic [7:0] b);
        int n;
        n = 0;
        @(posedge ref_clk);
        op <= o;
        op_byte <= b;
        op_valid <= 1'b1;
        do begin
            @(negedge ref_clk);
            n++;
        end while (op_ready !== 1'b1 && n < 300);
        if (n >= 300) begin
            err_count++;
            close_out();
        end
        @(posedge ref_clk);
        op_valid <= 1'b0;
    endtask
    task automatic read_exp(input logic [7:0] exp);
        int n;
        send(OP_READ, 8'h00);
        for (n = 0; n < 10 && rd_valid !== 1'b1; n++) @(negedge ref_clk);
        chk8({7'h00, rd_valid}, 8'h01, "read answer");
        chk8(rd_data, exp, "read data");
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int n = 0; n < 400 && init_done !== 1'b1; n++) @(negedge ref_clk);
        chk8({7'h00, init_done}, 8'h01, "init");
        $display("test init done");
        @(posedge ref_clk);
        guard_release <= 1'b1;
        send(OP_CMD, 8'h00);
        send(OP_ADDR5, 8'h00);
        send(OP_CMD, 8'h30);
        repeat (5) @(negedge ref_clk);
        chk8({7'h00, target_busy}, 8'h01, "fetch busy");
        send(OP_CMD, 8'h00);
        read_exp(8'ha5);
        read_exp(8'ha6);
        chk8({7'h00, addr_bad}, 8'h00, "address high bits");
        $display("test read done");
        send(OP_CMD, 8'h80);
        send(OP_ADDR5, 8'h00);
        send(OP_WRITE, 8'h3c);
        send(OP_CMD, 8'h10);
        op <= OP_WRITE;
        repeat (30) @(negedge ref_clk);
        chk8({7'h00, op_ready}, 8'h00, "write while busy");
        chk8(last_din, 8'h3c, "data in");
        @(posedge ref_clk);
        op <= OP_CMD;
        op_byte <= CMD_STATUS;
        @(negedge ref_clk);
        chk8({7'h00, op_ready}, 8'h01, "status while busy");
        send(OP_WRITE, 8'h55);
        repeat (6) @(negedge ref_clk);
        chk8(last_din, 8'h55, "data in after busy");
        $display("test program done");
        @(posedge ref_clk);
        op_target <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            send(OP_CMD, i ? CMD_STATUS_MULTI : CMD_STATUS);
            read_exp(8'he0);
        end
        send(OP_CMD, CMD_RESET);
        repeat (5) @(negedge ref_clk);
        chk8({7'h00, target_busy}, 8'h01, "second busy");
        $display("test second select done");
        close_out();
    end
endmodule
